//--- rtl/xorx_regs.svh
`ifndef XORX_REGS_SVH
`define XORX_REGS_SVH
// Contract
// - xor operands, write destination, update N Z only
// - port destination reads output latch, not pins
// - 63 dir imm: three bytes, three states
// - direct port access adds a state; 62 adds two, sub 5 adds none
// - 64 imm into accumulator: two bytes, one state
// - 66/67 indirect into accumulator, prefixed in source
// - bank register into accumulator, prefixed in source
// - 6c byte register pair, prefixed in binary
// - 6d word register pair, 3/2 states
// - 6e immediate byte into register, 3/2 states
// - sub 4 sixteen-bit immediate, 4/3 states
// - sub 1 direct byte into register
// - sub 5 direct operand into word register
// - sub 3/7 use two address bytes
// - sub 9 memory via word pointer
// - sub b memory via double-word pointer

`define XORX_PREFIX     8'ha5
`define XORX_OP_DIR_A   8'h62
`define XORX_OP_DIR_IMM 8'h63
`define XORX_OP_A_IMM   8'h64
`define XORX_OP_A_DIR   8'h65
`define XORX_OP_A_IND   7'h33
`define XORX_OP_A_RN    5'h0d
`define XORX_OP_RR      8'h6c
`define XORX_OP_WW      8'h6d
`define XORX_OP_EXT     8'h6e

`define XORX_SUB_R_IMM   4'h0
`define XORX_SUB_R_DIRECT_BYTE_ADDRESS  4'h1
`define XORX_SUB_R_DIRECT_WIDE_ADDRESS 4'h3
`define XORX_SUB_W_IMM   4'h4
`define XORX_SUB_W_DIRECT_BYTE_ADDRESS  4'h5
`define XORX_SUB_W_DIRECT_WIDE_ADDRESS 4'h7
`define XORX_SUB_R_INDW  4'h9
`define XORX_SUB_R_INDD  4'hb

// lengths exclude the prefix; states exclude the prefix state
`define XORX_LEN_1       3'h1
`define XORX_LEN_2       3'h2
`define XORX_LEN_3       3'h3
`define XORX_LEN_4       3'h4
`define XORX_LEN_PEND    3'h7
`define XORX_ST_1        3'h1
`define XORX_ST_2        3'h2
`define XORX_ST_3        3'h3
`define XORX_PEN_DIR_A   3'h2
`define XORX_PEN_DIRECT  3'h1

`define XORX_ACC_IDX     4'hb
`define XORX_PORT_ADDRS  32'hb0a09080
`endif

//--- rtl/xorx_pkg.sv
package xorx_pkg;
  typedef enum logic [1:0] {
    XORX_SZ_BYTE  = 2'h0,
    XORX_SZ_WORD  = 2'h1,
    XORX_SZ_DWORD = 2'h2
  } xorx_size_t;

  typedef enum logic [4:0] {
    XORX_F_NONE, XORX_F_DIR_A, XORX_F_DIR_IMM, XORX_F_A_IMM, XORX_F_A_DIR,
    XORX_F_A_IND, XORX_F_A_RN, XORX_F_RR, XORX_F_WW, XORX_F_R_IMM,
    XORX_F_W_IMM, XORX_F_R_DIRECT_BYTE_ADDRESS, XORX_F_W_DIRECT_BYTE_ADDRESS, XORX_F_R_DIRECT_WIDE_ADDRESS,
    XORX_F_W_DIRECT_WIDE_ADDRESS, XORX_F_R_INDW, XORX_F_R_INDD
  } xorx_form_t;

  typedef struct packed {
    logic [3:0] idx;
    xorx_size_t size;
  } xorx_rf_rd_t;

  typedef struct packed {
    logic        en;
    logic [3:0]  idx;
    xorx_size_t  size;
    logic [15:0] data;
  } xorx_rf_wr_t;
endpackage

//--- rtl/xorx_form_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "xorx_regs.svh"
module xorx_form_decode (
  // mode and prefix
  input  wire logic               binary_mode,
  input  wire logic               esc,
  // bytes
  input  wire logic [7:0]         opcode,
  input  wire logic [7:0]         sub_byte,
  input  wire logic               have_sub,
  // result
  output xorx_pkg::xorx_form_t    form,
  output logic                    legal,
  output logic [2:0]              len,
  output logic [2:0]              base,
  output logic [2:0]              pen
);
  logic native;
  logic need_sub;

  always_comb begin
    native   = binary_mode ^ esc;
    form     = xorx_pkg::XORX_F_NONE;
    len      = `XORX_LEN_PEND;
    base     = `XORX_ST_1;
    pen      = 3'h0;
    need_sub = 1'b0;
    if (!esc && opcode == `XORX_OP_DIR_A) begin
      form = xorx_pkg::XORX_F_DIR_A;
      len  = `XORX_LEN_2;
      base = `XORX_ST_2;
      pen  = `XORX_PEN_DIR_A;
    end else if (!esc && opcode == `XORX_OP_DIR_IMM) begin
      form = xorx_pkg::XORX_F_DIR_IMM;
      len  = `XORX_LEN_3;
      base = `XORX_ST_3;
      pen  = `XORX_PEN_DIRECT;
    end else if (!esc && opcode == `XORX_OP_A_IMM) begin
      form = xorx_pkg::XORX_F_A_IMM;
      len  = `XORX_LEN_2;
    end else if (!esc && opcode == `XORX_OP_A_DIR) begin
      form = xorx_pkg::XORX_F_A_DIR;
      len  = `XORX_LEN_2;
      pen  = `XORX_PEN_DIRECT;
    end else if (native && opcode[7:1] == `XORX_OP_A_IND) begin
      form = xorx_pkg::XORX_F_A_IND;
      len  = `XORX_LEN_1;
      base = `XORX_ST_2;
    end else if (native && opcode[7:3] == `XORX_OP_A_RN) begin
      form = xorx_pkg::XORX_F_A_RN;
      len  = `XORX_LEN_1;
    end else if (!native && opcode == `XORX_OP_RR) begin
      form = xorx_pkg::XORX_F_RR;
      len  = `XORX_LEN_2;
    end else if (!native && opcode == `XORX_OP_WW) begin
      form = xorx_pkg::XORX_F_WW;
      len  = `XORX_LEN_2;
      base = `XORX_ST_2;
    end else if (!native && opcode == `XORX_OP_EXT) begin
      need_sub = 1'b1;
      if (have_sub) begin
        case (sub_byte[3:0])
          `XORX_SUB_R_IMM: begin
            form = xorx_pkg::XORX_F_R_IMM;
            len  = `XORX_LEN_3;
            base = `XORX_ST_2;
          end
          `XORX_SUB_W_IMM: begin
            form = xorx_pkg::XORX_F_W_IMM;
            len  = `XORX_LEN_4;
            base = `XORX_ST_3;
          end
          `XORX_SUB_R_DIRECT_BYTE_ADDRESS: begin
            form = xorx_pkg::XORX_F_R_DIRECT_BYTE_ADDRESS;
            len  = `XORX_LEN_3;
            base = `XORX_ST_2;
            pen  = `XORX_PEN_DIRECT;
          end
          `XORX_SUB_W_DIRECT_BYTE_ADDRESS: begin
            form = xorx_pkg::XORX_F_W_DIRECT_BYTE_ADDRESS;
            len  = `XORX_LEN_3;
            base = `XORX_ST_3;
          end
          `XORX_SUB_R_DIRECT_WIDE_ADDRESS: begin
            form = xorx_pkg::XORX_F_R_DIRECT_WIDE_ADDRESS;
            len  = `XORX_LEN_4;
            base = `XORX_ST_2;
          end
          `XORX_SUB_W_DIRECT_WIDE_ADDRESS: begin
            form = xorx_pkg::XORX_F_W_DIRECT_WIDE_ADDRESS;
            len  = `XORX_LEN_4;
            base = `XORX_ST_3;
          end
          `XORX_SUB_R_INDW: begin
            form = xorx_pkg::XORX_F_R_INDW;
            len  = `XORX_LEN_3;
            base = `XORX_ST_2;
          end
          `XORX_SUB_R_INDD: begin
            form = xorx_pkg::XORX_F_R_INDD;
            len  = `XORX_LEN_3;
            base = `XORX_ST_3;
          end
          default: form = xorx_pkg::XORX_F_NONE;
        endcase
      end
    end
    legal = (form != xorx_pkg::XORX_F_NONE) || (need_sub && !have_sub);
  end
endmodule
`default_nettype wire

//--- rtl/xorx_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "xorx_regs.svh"
module xorx_exec #(
  parameter logic [31:0] PORT_ADDRS = `XORX_PORT_ADDRS
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // mode strap pin
  input  wire logic                  binary_mode_pin,
  // instruction byte stream
  input  wire logic                  op_valid,
  input  wire logic [7:0]            op_byte,
  output logic                       op_ready,
  // register file reads
  output xorx_pkg::xorx_rf_rd_t      rf_rd_a,
  input  wire logic [15:0]           rf_a_data,
  output xorx_pkg::xorx_rf_rd_t      rf_rd_b,
  input  wire logic [31:0]           rf_b_data,
  // data memory and port latches
  output logic [23:0]                mem_addr,
  output logic                       mem_rd,
  output logic                       mem_word,
  input  wire logic [15:0]           mem_rdata,
  input  wire logic [31:0]           port_latch,
  // results
  output xorx_pkg::xorx_rf_wr_t      rf_wr,
  output logic                       mem_wr_en,
  output logic [7:0]                 mem_wr_data,
  output logic                       flag_we,
  output logic                       neg_flag,
  output logic                       zero_flag,
  output logic                       done,
  output logic                       unsupported
);
  typedef enum logic [1:0] {
    XORX_S_FETCH = 2'b01,
    XORX_S_EXEC  = 2'b10
  } xorx_state_t;

  xorx_state_t          state_reg;
  logic [7:0]           buf_reg [0:4];
  logic [7:0]           bn [0:4];
  logic [2:0]           cnt_reg;
  logic                 esc_reg;
  logic [2:0]           exe_cnt_reg;
  logic                 first_reg;
  xorx_pkg::xorx_form_t form_reg;
  logic [15:0]          imm_reg;
  logic                 port_dst_reg;
  logic [1:0]           port_idx_reg;
  logic                 sync1_reg, sync2_reg, vld1_reg, vld2_reg;
  logic                 mode_ok_reg, binary_reg;
  xorx_pkg::xorx_form_t d_form;
  logic                 d_legal;
  logic [2:0]           d_len, d_base, d_pen;
  logic                 take, is_prefix, finish, bad;
  logic [7:0]           direct_byte_address;
  logic                 port_hit;
  logic [1:0]           port_idx;
  xorx_pkg::xorx_rf_rd_t a_next, b_next;
  logic [23:0]          maddr_next;
  logic                 mrd_next, mword_next;
  logic [15:0]          imm_next;
  logic                 last;
  logic [7:0]           dirval;
  logic [15:0]          dst, src, res;
  logic                 wide, to_mem;

  // strap: two flops, then captured once after release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg   <= 1'b0;
      sync2_reg   <= 1'b0;
      vld1_reg    <= 1'b0;
      vld2_reg    <= 1'b0;
      mode_ok_reg <= 1'b0;
      binary_reg  <= 1'b0;
    end else begin
      sync1_reg <= binary_mode_pin;
      sync2_reg <= sync1_reg;
      vld1_reg  <= 1'b1;
      vld2_reg  <= vld1_reg;
      if (vld2_reg && !mode_ok_reg) begin
        binary_reg  <= sync2_reg;
        mode_ok_reg <= 1'b1;
      end
    end
  end

  assign take      = op_ready && op_valid;
  assign is_prefix = (cnt_reg == 3'h0) && !esc_reg && (op_byte == `XORX_PREFIX);

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      bn[i] = (take && cnt_reg == 3'(i)) ? op_byte : buf_reg[i];
    end
  end

  xorx_form_decode u_dec (
    .binary_mode (binary_reg),
    .esc         (esc_reg),
    .opcode      (bn[0]),
    .sub_byte    (bn[1]),
    .have_sub    (take ? (cnt_reg >= 3'h1) : (cnt_reg >= 3'h2)),
    .form        (d_form),
    .legal       (d_legal),
    .len         (d_len),
    .base        (d_base),
    .pen         (d_pen)
  );

  assign bad    = take && !is_prefix && !d_legal;
  assign finish = take && !is_prefix && d_legal && (cnt_reg + 3'h1 == d_len);

  // operand selection for the instruction that completes this cycle
  always_comb begin
    a_next     = '{idx: `XORX_ACC_IDX, size: xorx_pkg::XORX_SZ_BYTE};
    b_next     = '{idx: 4'h0, size: xorx_pkg::XORX_SZ_BYTE};
    direct_byte_address       = bn[1];
    maddr_next = {16'h0000, bn[1]};
    mrd_next   = 1'b0;
    mword_next = 1'b0;
    imm_next   = {8'h00, bn[1]};
    case (d_form)
      xorx_pkg::XORX_F_DIR_A: mrd_next = 1'b1;
      xorx_pkg::XORX_F_DIR_IMM: begin
        mrd_next = 1'b1;
        imm_next = {8'h00, bn[2]};
      end
      xorx_pkg::XORX_F_A_DIR: mrd_next = 1'b1;
      xorx_pkg::XORX_F_A_IND: begin
        b_next.idx = {3'h0, bn[0][0]};
        mrd_next   = 1'b1;
      end
      xorx_pkg::XORX_F_A_RN: b_next.idx = {1'b0, bn[0][2:0]};
      xorx_pkg::XORX_F_RR, xorx_pkg::XORX_F_WW: begin
        a_next.idx = bn[1][7:4];
        b_next.idx = bn[1][3:0];
        if (d_form == xorx_pkg::XORX_F_WW) begin
          a_next.size = xorx_pkg::XORX_SZ_WORD;
          b_next.size = xorx_pkg::XORX_SZ_WORD;
        end
      end
      xorx_pkg::XORX_F_R_IMM, xorx_pkg::XORX_F_W_IMM: begin
        a_next.idx = bn[1][7:4];
        imm_next   = {8'h00, bn[2]};
        if (d_form == xorx_pkg::XORX_F_W_IMM) begin
          a_next.size = xorx_pkg::XORX_SZ_WORD;
          imm_next    = {bn[2], bn[3]};
        end
      end
      xorx_pkg::XORX_F_R_DIRECT_BYTE_ADDRESS, xorx_pkg::XORX_F_W_DIRECT_BYTE_ADDRESS,
      xorx_pkg::XORX_F_R_DIRECT_WIDE_ADDRESS, xorx_pkg::XORX_F_W_DIRECT_WIDE_ADDRESS: begin
        a_next.idx = bn[1][7:4];
        direct_byte_address       = bn[2];
        mrd_next   = 1'b1;
        maddr_next = {16'h0000, bn[2]};
        if (d_form == xorx_pkg::XORX_F_R_DIRECT_WIDE_ADDRESS || d_form == xorx_pkg::XORX_F_W_DIRECT_WIDE_ADDRESS) begin
          maddr_next = {8'h00, bn[2], bn[3]};
        end
        if (d_form == xorx_pkg::XORX_F_W_DIRECT_BYTE_ADDRESS || d_form == xorx_pkg::XORX_F_W_DIRECT_WIDE_ADDRESS) begin
          a_next.size = xorx_pkg::XORX_SZ_WORD;
          mword_next  = 1'b1;
        end
      end
      xorx_pkg::XORX_F_R_INDW, xorx_pkg::XORX_F_R_INDD: begin
        a_next.idx  = bn[2][7:4];
        b_next.idx  = bn[1][7:4];
        b_next.size = (d_form == xorx_pkg::XORX_F_R_INDD) ? xorx_pkg::XORX_SZ_DWORD : xorx_pkg::XORX_SZ_WORD;
        mrd_next    = 1'b1;
      end
      default: mrd_next = 1'b0;
    endcase
    port_hit = 1'b0;
    port_idx = 2'h0;
    for (int p = 0; p < 4; p++) begin
      if (direct_byte_address == PORT_ADDRS[p*8 +: 8]) begin
        port_hit = 1'b1;
        port_idx = 2'(p);
      end
    end
  end

  // fetch and sequencing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= XORX_S_FETCH;
      cnt_reg     <= 3'h0;
      esc_reg     <= 1'b0;
      exe_cnt_reg <= 3'h0;
      first_reg   <= 1'b0;
      op_ready    <= 1'b0;
      unsupported <= 1'b0;
      for (int i = 0; i < 5; i++) begin
        buf_reg[i] <= 8'h00;
      end
    end else begin
      unsupported <= bad;
      case (state_reg)
        XORX_S_FETCH: begin
          op_ready <= mode_ok_reg && !finish;
          if (take && is_prefix) begin
            esc_reg <= 1'b1;
          end else if (bad) begin
            cnt_reg <= 3'h0;
            esc_reg <= 1'b0;
          end else if (take) begin
            buf_reg[cnt_reg] <= op_byte;
            cnt_reg          <= cnt_reg + 3'h1;
            if (finish) begin
              state_reg   <= XORX_S_EXEC;
              first_reg   <= 1'b1;
              exe_cnt_reg <= d_base + {2'h0, esc_reg} + (port_hit ? d_pen : 3'h0);
            end
          end
        end
        XORX_S_EXEC: begin
          first_reg   <= 1'b0;
          exe_cnt_reg <= exe_cnt_reg - 3'h1;
          if (last) begin
            state_reg <= XORX_S_FETCH;
            cnt_reg   <= 3'h0;
            esc_reg   <= 1'b0;
            op_ready  <= 1'b1;
          end
        end
        default: state_reg <= XORX_S_FETCH;
      endcase
    end
  end

  assign last = (state_reg == XORX_S_EXEC) && (exe_cnt_reg == 3'h1);

  // operand addressing; indirect address is taken from the pointer in the first state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      form_reg     <= xorx_pkg::XORX_F_NONE;
      rf_rd_a      <= '{idx: 4'h0, size: xorx_pkg::XORX_SZ_BYTE};
      rf_rd_b      <= '{idx: 4'h0, size: xorx_pkg::XORX_SZ_BYTE};
      mem_addr     <= 24'h000000;
      mem_rd       <= 1'b0;
      mem_word     <= 1'b0;
      imm_reg      <= 16'h0000;
      port_dst_reg <= 1'b0;
      port_idx_reg <= 2'h0;
    end else if (finish) begin
      form_reg     <= d_form;
      rf_rd_a      <= a_next;
      rf_rd_b      <= b_next;
      mem_addr     <= maddr_next;
      mem_rd       <= mrd_next;
      mem_word     <= mword_next;
      imm_reg      <= imm_next;
      port_dst_reg <= port_hit && (d_form == xorx_pkg::XORX_F_DIR_A || d_form == xorx_pkg::XORX_F_DIR_IMM);
      port_idx_reg <= port_idx;
    end else if (first_reg) begin
      case (form_reg)
        xorx_pkg::XORX_F_A_IND:  mem_addr <= {16'h0000, rf_b_data[7:0]};
        xorx_pkg::XORX_F_R_INDW: mem_addr <= {8'h00, rf_b_data[15:0]};
        xorx_pkg::XORX_F_R_INDD: mem_addr <= rf_b_data[23:0];
        default:                 mem_addr <= mem_addr;
      endcase
    end else if (last) begin
      mem_rd <= 1'b0;
    end
  end

  // combine in the final state
  always_comb begin
    dirval = port_dst_reg ? port_latch[port_idx_reg*8 +: 8] : mem_rdata[7:0];
    to_mem = (form_reg == xorx_pkg::XORX_F_DIR_A) || (form_reg == xorx_pkg::XORX_F_DIR_IMM);
    wide   = !to_mem && (rf_rd_a.size == xorx_pkg::XORX_SZ_WORD);
    dst    = rf_a_data;
    src    = mem_word ? mem_rdata : {8'h00, mem_rdata[7:0]};
    case (form_reg)
      xorx_pkg::XORX_F_DIR_A: begin
        dst = {8'h00, dirval};
        src = {8'h00, rf_a_data[7:0]};
      end
      xorx_pkg::XORX_F_DIR_IMM: begin
        dst = {8'h00, dirval};
        src = imm_reg;
      end
      xorx_pkg::XORX_F_A_IMM, xorx_pkg::XORX_F_R_IMM, xorx_pkg::XORX_F_W_IMM: src = imm_reg;
      xorx_pkg::XORX_F_A_RN, xorx_pkg::XORX_F_RR, xorx_pkg::XORX_F_WW: src = rf_b_data[15:0];
      default: src = mem_word ? mem_rdata : {8'h00, mem_rdata[7:0]};
    endcase
    res = dst ^ src;
    if (!wide) begin
      res[15:8] = 8'h00;
    end
  end

  // results; carry, auxiliary carry and overflow are never touched
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rf_wr       <= '{en: 1'b0, idx: 4'h0, size: xorx_pkg::XORX_SZ_BYTE, data: 16'h0000};
      mem_wr_en   <= 1'b0;
      mem_wr_data <= 8'h00;
      flag_we     <= 1'b0;
      neg_flag    <= 1'b0;
      zero_flag   <= 1'b0;
      done        <= 1'b0;
    end else begin
      rf_wr.en  <= last && !to_mem;
      mem_wr_en <= last && to_mem;
      flag_we   <= last;
      done      <= last;
      if (last) begin
        rf_wr.idx   <= rf_rd_a.idx;
        rf_wr.size  <= rf_rd_a.size;
        rf_wr.data  <= res;
        mem_wr_data <= res[7:0];
        neg_flag    <= wide ? res[15] : res[7];
        zero_flag   <= (res == 16'h0000);
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/xorx_exec_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "xorx_regs.svh"
module xorx_exec_props #(
  parameter logic [31:0] PORT_ADDRS = `XORX_PORT_ADDRS
) (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 nrst,
  // fetch side
  input wire logic                 binary_mode_pin,
  input wire logic                 op_valid,
  input wire logic [7:0]           op_byte,
  input wire logic                 op_ready,
  // results
  input wire xorx_pkg::xorx_rf_wr_t rf_wr,
  input wire logic                 mem_wr_en,
  input wire logic [7:0]           mem_wr_data,
  input wire logic                 flag_we,
  input wire logic                 neg_flag,
  input wire logic                 zero_flag,
  input wire logic                 done,
  input wire logic                 unsupported
);
  logic [2:0] cnt_reg;
  logic       pfx_reg;
  logic       take;
  logic       fin;
  logic [2:0] cnt_eff;
  logic       pfx_eff;
  logic       opf;

  function automatic logic is_port(input logic [7:0] a);
    return a == PORT_ADDRS[7:0] || a == PORT_ADDRS[15:8] || a == PORT_ADDRS[23:16] || a == PORT_ADDRS[31:24];
  endfunction

  // a new byte may be taken in the very cycle the previous instruction ends
  assign take    = op_valid && op_ready;
  assign fin     = done || unsupported;
  assign cnt_eff = fin ? 3'h0 : cnt_reg;
  assign pfx_eff = fin ? 1'b0 : pfx_reg;
  assign opf     = take && ((cnt_eff == 3'h0 && op_byte != `XORX_PREFIX) || (cnt_eff == 3'h1 && pfx_eff));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 3'h0;
    end else if (take) begin
      cnt_reg <= cnt_eff + 3'h1;
    end else if (fin) begin
      cnt_reg <= 3'h0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pfx_reg <= 1'b0;
    end else if (take && cnt_eff == 3'h0) begin
      pfx_reg <= op_byte == `XORX_PREFIX;
    end else if (fin) begin
      pfx_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_acc_imm_state: assert property (
    (opf && !pfx_eff && op_byte == `XORX_OP_A_IMM) ##1 take |=> !done ##1 done
  ) else $error("accumulator immediate form not done after one state");
  a_dir_imm_plain: assert property (
    (opf && !pfx_eff && op_byte == `XORX_OP_DIR_IMM) ##1 (take && !is_port(op_byte)) ##1 take
    |=> !done [*3] ##1 done
  ) else $error("direct immediate form not done after three states");
  a_dir_imm_port: assert property (
    (opf && !pfx_eff && op_byte == `XORX_OP_DIR_IMM) ##1 (take && is_port(op_byte)) ##1 take
    |=> !done [*4] ##1 done
  ) else $error("direct immediate port form missed its extra state");
  a_word_imm_bin: assert property (
    (binary_mode_pin && opf && pfx_eff && op_byte == `XORX_OP_EXT) ##1 (take && op_byte[3:0] == `XORX_SUB_W_IMM)
    ##1 take ##1 take |=> !done [*4] ##1 done
  ) else $error("wide immediate form not done after four states");
  a_ptr_byte_src: assert property (
    (!binary_mode_pin && opf && !pfx_eff && op_byte == `XORX_OP_EXT)
    ##1 (take && op_byte[3:0] == `XORX_SUB_R_INDW) ##1 (take && op_byte[3:0] == 4'h0) |=> !done [*2] ##1 done
  ) else $error("word pointer form not done after two states");
  a_port_src_pen: assert property (
    (!binary_mode_pin && opf && !pfx_eff && op_byte == `XORX_OP_EXT)
    ##1 (take && op_byte[3:0] == `XORX_SUB_R_DIRECT_BYTE_ADDRESS) ##1 (take && is_port(op_byte)) |=> !done [*3] ##1 done
  ) else $error("direct byte port source missed its extra state");
  a_flags_byte: assert property (
    rf_wr.en && rf_wr.size == xorx_pkg::XORX_SZ_BYTE
    |-> flag_we && neg_flag == rf_wr.data[7] && zero_flag == (rf_wr.data[7:0] == 8'h00)
  ) else $error("flags disagree with byte register result");
  a_flags_word: assert property (
    rf_wr.en && rf_wr.size == xorx_pkg::XORX_SZ_WORD
    |-> flag_we && neg_flag == rf_wr.data[15] && zero_flag == (rf_wr.data == 16'h0000)
  ) else $error("flags disagree with word register result");
  a_flags_mem: assert property (
    mem_wr_en |-> flag_we && done && neg_flag == mem_wr_data[7] && zero_flag == (mem_wr_data == 8'h00)
  ) else $error("flags disagree with memory result");
  a_unsup_quiet: assert property (
    unsupported |-> !done && !rf_wr.en && !mem_wr_en && !flag_we
  ) else $error("refused byte still produced a result");
endmodule
`default_nettype wire

//--- verif/xor_instruction_execution_test.sv
`timescale 1ns/1ps
`default_nettype none
module xor_instruction_execution_test;
  logic                  clk;
  logic                  nrst;
  logic                  binary_mode_pin;
  logic                  op_valid;
  logic [7:0]            op_byte;
  logic                  op_ready;
  xorx_pkg::xorx_rf_rd_t rf_rd_a;
  xorx_pkg::xorx_rf_rd_t rf_rd_b;
  logic [15:0]           rf_a_data;
  logic [31:0]           rf_b_data;
  logic [23:0]           mem_addr;
  logic                  mem_rd;
  logic                  mem_word;
  logic [15:0]           mem_rdata;
  logic [31:0]           port_latch;
  xorx_pkg::xorx_rf_wr_t rf_wr;
  logic                  mem_wr_en;
  logic [7:0]            mem_wr_data;
  logic                  flag_we;
  logic                  neg_flag;
  logic                  zero_flag;
  logic                  done;
  logic                  unsupported;
  int                    err_count;
  int                    checked;

  xorx_exec dut (
    .clk(clk), .nrst(nrst), .binary_mode_pin(binary_mode_pin), .op_valid(op_valid), .op_byte(op_byte),
    .op_ready(op_ready), .rf_rd_a(rf_rd_a), .rf_a_data(rf_a_data), .rf_rd_b(rf_rd_b), .rf_b_data(rf_b_data),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_word(mem_word), .mem_rdata(mem_rdata), .port_latch(port_latch),
    .rf_wr(rf_wr), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .flag_we(flag_we), .neg_flag(neg_flag),
    .zero_flag(zero_flag), .done(done), .unsupported(unsupported)
  );

  // register contents depend on the index only, so a wrong index shows up in the result
  assign rf_a_data = {rf_rd_a.idx ^ 4'h5, 4'h3, rf_rd_a.idx, 4'hc};
  assign rf_b_data = {8'h00, 8'h01, rf_rd_b.idx ^ 4'ha, 4'h6, rf_rd_b.idx, 4'h9};
  assign mem_rdata = mem_addr[15:0] ^ 16'h5a3c;

  always #5 clk = ~clk;

  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results;
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic do_reset(input logic mode);
    @(posedge clk);
    nrst <= 1'b0;
    binary_mode_pin <= mode;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // bytes are right aligned in by, first byte highest; states counted from the last byte taken
  task automatic exec(input logic [47:0] by, input int n, input int s, input logic bad);
    int k;
    int c;
    @(posedge clk);
    for (k = 0; k < n; k++) begin
      op_valid <= 1'b1;
      op_byte <= by[8*(n-1-k) +: 8];
      @(posedge clk);
      while (op_ready !== 1'b1) @(posedge clk);
    end
    op_valid <= 1'b0;
    // a refusal pulses only in the cycle right after the offending byte is taken
    #1;
    c = 0;
    if (bad) begin
      chk("unsupported", unsupported, 1'b1);
      chk("done", done, 1'b0);
    end else begin
      do begin
        @(posedge clk);
        #1;
        c++;
      end while (done !== 1'b1 && unsupported !== 1'b1 && c < 12);
      chk("states", 24'(c), 24'(s));
      chk("op_ready", op_ready, 1'b1);
    end
  endtask

  task automatic chk_rf(input logic [3:0] idx, input logic wide, input logic [15:0] d);
    chk("rf_wr.en", rf_wr.en, 1'b1);
    chk("rf_wr.idx", rf_wr.idx, idx);
    chk("rf_wr.size", rf_wr.size, wide ? xorx_pkg::XORX_SZ_WORD : xorx_pkg::XORX_SZ_BYTE);
    chk("rf_wr.data", wide ? rf_wr.data : {8'h00, rf_wr.data[7:0]}, d);
    chk("neg_flag", neg_flag, wide ? d[15] : d[7]);
    chk("zero_flag", zero_flag, d == 16'h0000);
    chk("flag_we", flag_we, 1'b1);
  endtask

  task automatic chk_mem(input logic [7:0] a, input logic [7:0] d);
    chk("mem_wr_en", mem_wr_en, 1'b1);
    chk("mem_addr", mem_addr[7:0], a);
    chk("mem_wr_data", mem_wr_data, d);
    chk("neg_flag", neg_flag, d[7]);
    chk("zero_flag", zero_flag, d == 8'h00);
  endtask

  task automatic t_acc_imm;
    exec(48'h6455, 2, 1, 1'b0);
    chk_rf(4'hb, 1'b0, 16'h00e9);
    exec(48'h64bc, 2, 1, 1'b0);
    chk_rf(4'hb, 1'b0, 16'h0000);
  endtask

  task automatic t_dir_imm;
    exec(48'h63300f, 3, 3, 1'b0);
    chk_mem(8'h30, 8'h03);
    chk("mem_rd", mem_rd, 1'b0);
    // port 1 destination must start from its output latch
    exec(48'h6390ff, 3, 4, 1'b0);
    chk_mem(8'h90, 8'hdd);
    exec(48'h6230, 2, 2, 1'b0);
    chk_mem(8'h30, 8'hb0);
    exec(48'h62a0, 2, 4, 1'b0);
    chk_mem(8'ha0, 8'h8f);
    exec(48'h6590, 2, 2, 1'b0);
    chk_rf(4'hb, 1'b0, 16'h0010);
  endtask

  task automatic t_bin_regs;
    exec(48'ha56e241234, 5, 4, 1'b0);
    chk_rf(4'h2, 1'b1, 16'h6118);
    exec(48'ha56c37, 3, 2, 1'b0);
    chk_rf(4'h3, 1'b0, 16'h0045);
    exec(48'ha56d24, 3, 3, 1'b0);
    chk_rf(4'h2, 1'b1, 16'h9565);
  endtask

  task automatic t_illegal;
    exec(48'ha562, 2, 0, 1'b1);
    exec(48'ha56e32, 3, 0, 1'b1);
  endtask

  task automatic t_src_mode;
    exec(48'h6c37, 2, 1, 1'b0);
    chk_rf(4'h3, 1'b0, 16'h0045);
    exec(48'ha56b, 2, 2, 1'b0);
    chk_rf(4'hb, 1'b0, 16'h0085);
    exec(48'ha567, 2, 3, 1'b0);
    chk_rf(4'hb, 1'b0, 16'h0099);
    exec(48'h6e30a1, 3, 2, 1'b0);
    chk_rf(4'h3, 1'b0, 16'h009d);
    exec(48'h6e3180, 3, 3, 1'b0);
    chk_rf(4'h3, 1'b0, 16'h0080);
    exec(48'h6e5520, 3, 3, 1'b0);
    chk_rf(4'h5, 1'b1, 16'h5940);
    chk("mem_word", mem_word, 1'b1);
    exec(48'h6e570040, 4, 3, 1'b0);
    chk_rf(4'h5, 1'b1, 16'h5920);
    exec(48'h6e4950, 3, 2, 1'b0);
    chk_rf(4'h5, 1'b0, 16'h0029);
    chk("rf_rd_b.idx", rf_rd_b.idx, 4'h4);
    chk("rf_rd_b.size", rf_rd_b.size, xorx_pkg::XORX_SZ_WORD);
    exec(48'h6e4b50, 3, 3, 1'b0);
    chk_rf(4'h5, 1'b0, 16'h0029);
    chk("rf_rd_b.size", rf_rd_b.size, xorx_pkg::XORX_SZ_DWORD);
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    binary_mode_pin = 1'b1;
    op_valid = 1'b0;
    op_byte = 8'h00;
    port_latch = 32'h44332211;
    err_count = 0;
    checked = 0;
    do_reset(1'b1);
    t_acc_imm();
    t_dir_imm();
    t_bin_regs();
    t_illegal();
    // the mode strap is only taken after a reset
    do_reset(1'b0);
    t_src_mode();
    results();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    #50000;
    err_count++;
    results();
  end
endmodule

bind xorx_exec xorx_exec_props #(.PORT_ADDRS(PORT_ADDRS)) u_props (
  .clk(clk), .nrst(nrst), .binary_mode_pin(binary_mode_pin), .op_valid(op_valid), .op_byte(op_byte),
  .op_ready(op_ready), .rf_wr(rf_wr), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .flag_we(flag_we),
  .neg_flag(neg_flag), .zero_flag(zero_flag), .done(done), .unsupported(unsupported)
);
`default_nettype wire
